// ==== logic/bmc_pkg.sv ====
// Shared constants and carrier types for the biphase-mark line codec.
// Assumes a 40 MHz core clock and one configuration-channel pin pair.
package bmc_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_HZ          = 40_000_000;
    localparam int BIT_RATE_HZ     = 300_000;
    localparam int HALF_CELL_CYC   = CLK_HZ / (2 * BIT_RATE_HZ);
    localparam int CNT_W           = 8;
    // Receive thresholds in core cycles, relative to one half cell.
    localparam logic [CNT_W-1:0] RX_MIN_HALF = CNT_W'(HALF_CELL_CYC / 2);
    localparam logic [CNT_W-1:0] RX_SPLIT    = CNT_W'((HALF_CELL_CYC * 3) / 2);
    localparam logic [CNT_W-1:0] RX_MAX_FULL = CNT_W'(HALF_CELL_CYC * 3);
    localparam int PRE_LOW_CYC     = HALF_CELL_CYC;
    localparam int FIFO_DEPTH      = 16;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic bit_val;   // Encoded bit value.
        logic last;      // Final bit of the message.
    } tx_bit_t;

    typedef struct packed {
        logic in_val;    // Sampled level from the line.
        logic out_val;   // Level to drive.
        logic out_en;    // High while this end drives.
    } line_pin_t;

endpackage : bmc_pkg

// ==== logic/bit_fifo.sv ====
// Parameterised first-in first-out buffer with valid and ready on both sides.
// Assumes a single clock, synchronous active high reset and a clock enable.
`timescale 1ns/10ps
`default_nettype none
module bit_fifo #(
    parameter int WIDTH = 2,
    parameter int DEPTH = 16
) (
    input  wire logic             clk_in,      // Core clock.
    input  wire logic             srst_in,     // Synchronous reset.
    input  wire logic             ce_in,       // Clock enable.
    input  wire logic [WIDTH-1:0] wr_data_in,  // Write word.
    input  wire logic             wr_valid_in, // Write request.
    output logic                  wr_ready_out,// Room for a word.
    output logic [WIDTH-1:0]      rd_data_out, // Head word.
    output logic                  rd_valid_out,// Head word present.
    input  wire logic             rd_ready_in  // Head word taken.
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wp_q;
    logic [AW-1:0]    rp_q;
    logic [AW:0]      cnt_q;
    logic             push;
    logic             pop;

    // Handshakes derived from the fill count.
    assign wr_ready_out = (cnt_q != (AW+1)'(DEPTH));
    assign rd_valid_out = (cnt_q != '0);
    assign rd_data_out  = mem_q[rp_q];
    assign push         = ce_in && wr_valid_in && wr_ready_out;
    assign pop          = ce_in && rd_ready_in && rd_valid_out;

    // Storage array write.
    always_ff @(posedge clk_in) begin
        if (push) begin
            mem_q[wp_q] <= wr_data_in;
        end
    end

    // Pointers and fill count.
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wp_q <= (wp_q == AW'(DEPTH-1)) ? '0 : wp_q + 1'b1;
            end
            if (pop) begin
                rp_q <= (rp_q == AW'(DEPTH-1)) ? '0 : rp_q + 1'b1;
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + 1'b1;
            end else if (pop && !push) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end

    AST_FIFO_NO_OVERFLOW: assert property (@(posedge clk_in) disable iff (srst_in)
        cnt_q <= (AW+1)'(DEPTH)) else $error("FIFO count above depth.");

endmodule : bit_fifo
`default_nettype wire

// ==== logic/bmc_rx.sv ====
// Biphase-mark receiver that times transitions between line edges.
// Assumes the line level is synchronous to the core clock.
`timescale 1ns/10ps
`default_nettype none
module bmc_rx
    import bmc_pkg::*;
(
    input  wire logic clk_in,       // Core clock.
    input  wire logic srst_in,      // Synchronous reset.
    input  wire logic ce_in,        // Clock enable.
    input  wire logic enable_in,    // Receive allowed.
    input  wire logic line_in,      // Line level.
    output logic      bit_out,      // Decoded bit.
    output logic      bit_vld_out   // One-cycle pulse per bit.
);
    logic             prev_q;
    logic [CNT_W-1:0] cnt_q;
    logic             half_q;
    logic             edge_seen;

    assign edge_seen = (line_in != prev_q);

    // Interval timing and decision.
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            prev_q      <= 1'b0;
            cnt_q       <= '0;
            half_q      <= 1'b0;
            bit_out     <= 1'b0;
            bit_vld_out <= 1'b0;
        end else if (ce_in) begin
            prev_q      <= line_in;
            bit_vld_out <= 1'b0;
            if (!enable_in) begin
                cnt_q  <= '0;
                half_q <= 1'b0;
            end else if (edge_seen) begin
                cnt_q <= '0;
                if (cnt_q < RX_MIN_HALF || cnt_q > RX_MAX_FULL) begin
                    half_q <= 1'b0;                              // Glitch or idle gap.
                end else if (cnt_q < RX_SPLIT) begin
                    if (half_q) begin
                        bit_out     <= 1'b1;
                        bit_vld_out <= 1'b1;
                        half_q      <= 1'b0;
                    end else begin
                        half_q <= 1'b1;
                    end
                end else begin
                    bit_out     <= 1'b0;
                    bit_vld_out <= 1'b1;
                    half_q      <= 1'b0;
                end
            end else if (cnt_q != {CNT_W{1'b1}}) begin
                cnt_q <= cnt_q + 1'b1;
            end
        end
    end

    AST_RX_PULSE: assert property (@(posedge clk_in) disable iff (srst_in)
        bit_vld_out |=> !bit_vld_out) else $error("Receive pulse lasted two cycles.");

endmodule : bmc_rx
`default_nettype wire

// ==== logic/pd_bmc_line_codec.sv ====
// Biphase-mark line codec with tri-state driver control for the CC wire pair.
// Assumes a protocol engine supplies bits with a last marker and consumes bits.
`timescale 1ns/10ps
`default_nettype none
module pd_bmc_line_codec
    import bmc_pkg::*;
#(
    parameter int HALF_CYC  = HALF_CELL_CYC,
    parameter int DEPTH     = FIFO_DEPTH
) (
    input  wire logic  clk_in,        // Core clock, 40 MHz.
    input  wire logic  srst_in,       // Synchronous reset.
    input  wire logic  ce_in,         // Clock enable.
    input  wire logic  orient_b_in,   // High selects cc_line_b.
    input  wire logic  tx_bit_in,     // Bit to send.
    input  wire logic  tx_last_in,    // Bit is the last of the message.
    input  wire logic  tx_valid_in,   // Bit offered.
    output logic       tx_ready_out,  // Bit accepted.
    output logic       tx_busy_out,   // Message in progress.
    output logic       rx_bit_out,    // Received bit.
    output logic       rx_valid_out,  // Received bit pulse.
    input  wire logic  cc_line_a_in,  // Level on cc_line_a.
    output logic       cc_line_a_out, // Drive level for cc_line_a.
    output logic       cc_line_a_oe_out, // Drive enable for cc_line_a.
    input  wire logic  cc_line_b_in,  // Level on cc_line_b.
    output logic       cc_line_b_out, // Drive level for cc_line_b.
    output logic       cc_line_b_oe_out  // Drive enable for cc_line_b.
);
    import bmc_pkg::*;

    // ------------------------------------------------------------
    // Types and storage
    // ------------------------------------------------------------
    typedef enum logic [2:0] {ST_IDLE, ST_LEAD, ST_FIRST, ST_SECOND, ST_CLOSE, ST_TAIL} tx_st_t;

    tx_st_t           st_q;
    logic [CNT_W-1:0] tmr_q;
    logic             lvl_q;
    logic             drv_q;
    logic             sel_b_q;
    tx_bit_t          cur_q;
    tx_bit_t          wr_word;
    tx_bit_t          rd_word;
    logic             rd_valid;
    logic             rd_ready;
    logic             tmr_done;
    line_pin_t        sel_pin;
    logic             rx_enable;
    logic [CNT_W-1:0] lead_len_q;

    // ------------------------------------------------------------
    // Bit buffer between the protocol engine and the encoder
    // ------------------------------------------------------------
    // One assignment packs the offered bit and its end-of-message marker.
    assign wr_word = '{bit_val: tx_bit_in, last: tx_last_in};

    bit_fifo #(
        .WIDTH ($bits(tx_bit_t)),
        .DEPTH (DEPTH)
    ) u_fifo (
        .clk_in       (clk_in),
        .srst_in      (srst_in),
        .ce_in        (ce_in),
        .wr_data_in   (wr_word),
        .wr_valid_in  (tx_valid_in),
        .wr_ready_out (tx_ready_out),
        .rd_data_out  (rd_word),
        .rd_valid_out (rd_valid),
        .rd_ready_in  (rd_ready)
    );

    // ------------------------------------------------------------
    // Encoder state machine
    // ------------------------------------------------------------
    assign tmr_done = (tmr_q == '0);
    // A bit is taken only at a cell boundary; an empty buffer mid-message stalls the encoder.
    assign rd_ready = ((st_q == ST_LEAD) || (st_q == ST_SECOND)) && tmr_done && !cur_q.last;

    // Sequencing of lead-in, bit halves, closing edge and release.
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            st_q    <= ST_IDLE;
            tmr_q   <= '0;
            lvl_q   <= 1'b0;
            drv_q   <= 1'b0;
            sel_b_q <= 1'b0;
            cur_q   <= '0;
        end else if (ce_in) begin
            if (!tmr_done) begin
                tmr_q <= tmr_q - 1'b1;
            end
            unique case (st_q)
                ST_IDLE: begin
                    if (rd_valid) begin
                        st_q    <= ST_LEAD;
                        sel_b_q <= orient_b_in;
                        lvl_q   <= 1'b0;
                        drv_q   <= 1'b1;
                        cur_q   <= '0;
                        tmr_q   <= CNT_W'(HALF_CYC - 1);
                    end
                end
                ST_LEAD, ST_SECOND: begin
                    if (tmr_done) begin
                        if (cur_q.last) begin
                            st_q  <= ST_CLOSE;
                            lvl_q <= ~lvl_q;
                            tmr_q <= CNT_W'(HALF_CYC - 1);
                        end else if (rd_valid) begin
                            st_q  <= ST_FIRST;
                            cur_q <= rd_word;
                            lvl_q <= ~lvl_q;
                            tmr_q <= CNT_W'(HALF_CYC - 1);
                        end
                    end
                end
                ST_FIRST: begin
                    if (tmr_done) begin
                        st_q  <= ST_SECOND;
                        lvl_q <= lvl_q ^ cur_q.bit_val;
                        tmr_q <= CNT_W'(HALF_CYC - 1);
                    end
                end
                ST_CLOSE: begin
                    if (tmr_done) begin
                        st_q  <= ST_TAIL;
                        drv_q <= 1'b0;
                    end
                end
                ST_TAIL: begin
                    st_q  <= ST_IDLE;
                    cur_q <= '0;
                    lvl_q <= 1'b0;
                end
                default: begin
                    st_q  <= ST_IDLE;
                    drv_q <= 1'b0;
                    lvl_q <= 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Pin steering
    // ------------------------------------------------------------
    // Only the oriented line is driven; the other enable stays low.
    assign cc_line_a_out    = lvl_q;
    assign cc_line_b_out    = lvl_q;
    assign cc_line_a_oe_out = drv_q && !sel_b_q;
    assign cc_line_b_oe_out = drv_q && sel_b_q;
    assign tx_busy_out      = (st_q != ST_IDLE);

    // The selected pin is gathered in one assignment so the struct has a single driver.
    assign sel_pin = '{in_val:  (orient_b_in ? cc_line_b_in : cc_line_a_in),
                       out_val: lvl_q,
                       out_en:  drv_q};
    // Receiving is held off while this end drives, so only the far party is heard.
    assign rx_enable       = !sel_pin.out_en && (st_q == ST_IDLE);

    // ------------------------------------------------------------
    // Receiver
    // ------------------------------------------------------------
    bmc_rx u_rx (
        .clk_in      (clk_in),
        .srst_in     (srst_in),
        .ce_in       (ce_in),
        .enable_in   (rx_enable),
        .line_in     (sel_pin.in_val),
        .bit_out     (rx_bit_out),
        .bit_vld_out (rx_valid_out)
    );

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    AST_CELL_START_EDGE: assert property (@(posedge clk_in) disable iff (srst_in)
        ce_in && st_q == ST_SECOND && tmr_done && !cur_q.last && rd_valid
        |=> lvl_q != $past(lvl_q)) else $error("Bit cell began without an edge.");
    AST_MID_EDGE_ONE: assert property (@(posedge clk_in) disable iff (srst_in)
        ce_in && st_q == ST_FIRST && tmr_done
        |=> lvl_q == ($past(lvl_q) ^ $past(cur_q.bit_val))) else $error("Mid cell edge wrong.");
    AST_LEAD_LOW: assert property (@(posedge clk_in) disable iff (srst_in)
        st_q == ST_IDLE ##1 st_q == ST_LEAD |-> !lvl_q && drv_q) else $error("Lead-in not low.");
    AST_CLOSE_EDGE: assert property (@(posedge clk_in) disable iff (srst_in)
        $rose(st_q == ST_CLOSE) |-> lvl_q != $past(lvl_q)) else $error("No closing edge.");
    AST_IDLE_HIZ: assert property (@(posedge clk_in) disable iff (srst_in)
        st_q == ST_IDLE |-> !cc_line_a_oe_out && !cc_line_b_oe_out) else $error("Driving while idle.");
    AST_ONE_LINE: assert property (@(posedge clk_in) disable iff (srst_in)
        !(cc_line_a_oe_out && cc_line_b_oe_out)) else $error("Both lines driven.");
    AST_NO_RX_WHILE_TX: assert property (@(posedge clk_in) disable iff (srst_in)
        drv_q |-> !rx_enable) else $error("Receiver live while driving.");
    AST_RELEASE: assert property (@(posedge clk_in) disable iff (srst_in)
        st_q == ST_TAIL |-> !drv_q ##1 st_q == ST_IDLE) else $error("Driver not released.");

    // ------------------------------------------------------------
    // Check helpers
    // ------------------------------------------------------------
    // Counts enabled cycles spent in the low lead-in, so its length can be checked
    // without a long repetition in a property. It saturates so a stuck state cannot wrap.
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            lead_len_q <= '0;
        end else if (ce_in) begin
            if (st_q != ST_LEAD) begin
                lead_len_q <= '0;
            end else if (lead_len_q != {CNT_W{1'b1}}) begin
                lead_len_q <= lead_len_q + 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Further checks
    // ------------------------------------------------------------
    // The low lead-in lasts exactly one half cell before the first cell edge.
    AST_LEAD_LENGTH: assert property (@(posedge clk_in) disable iff (srst_in)
        ce_in && st_q == ST_LEAD && tmr_done
        |-> lead_len_q == CNT_W'(HALF_CYC - 1)) else $error("Lead-in length wrong.");

    // The level only moves at a half-cell boundary, never while the timer runs.
    AST_HOLD_MID_HALF: assert property (@(posedge clk_in) disable iff (srst_in)
        ce_in && !tmr_done && st_q != ST_IDLE
        |=> lvl_q == $past(lvl_q)) else $error("Level moved inside a half cell.");

    // A frozen clock enable keeps the encoder exactly where it was.
    AST_CE_FREEZE: assert property (@(posedge clk_in) disable iff (srst_in)
        !ce_in |=> st_q == $past(st_q) && lvl_q == $past(lvl_q) && drv_q == $past(drv_q))
        else $error("Encoder moved while frozen.");

    // The chosen line cannot swap while a message is on the wire.
    AST_SEL_STABLE: assert property (@(posedge clk_in) disable iff (srst_in)
        drv_q && $past(drv_q) |-> sel_b_q == $past(sel_b_q)) else $error("Line swapped mid message.");

    // Whenever this end drives, the engine sees a message in progress.
    AST_BUSY_DRIVE: assert property (@(posedge clk_in) disable iff (srst_in)
        drv_q |-> tx_busy_out) else $error("Driving without busy.");

    // The idle level is low, so the next lead-in starts from a known state.
    AST_IDLE_LOW: assert property (@(posedge clk_in) disable iff (srst_in)
        st_q == ST_IDLE |-> !lvl_q) else $error("Idle level not low.");

    // The driver lets go only on the way out of a message, after the closing edge.
    AST_DRIVE_ENDS: assert property (@(posedge clk_in) disable iff (srst_in)
        $fell(drv_q) |-> st_q == ST_TAIL) else $error("Driver released early.");

    COV_MSG_START: cover property (@(posedge clk_in) st_q == ST_IDLE ##1 st_q == ST_LEAD);
    COV_ONE_BIT: cover property (@(posedge clk_in) st_q == ST_FIRST && cur_q.bit_val);
    COV_CLOSE: cover property (@(posedge clk_in) st_q == ST_CLOSE);
    COV_RX_BIT: cover property (@(posedge clk_in) rx_valid_out);

endmodule : pd_bmc_line_codec
`default_nettype wire

// ==== testbench/cc_partner.sv ====
// Far-end model on the configuration-channel wire that sends biphase-mark frames.
// Assumes the bench resolves the wire with a pull-down and calls send_frame.
`timescale 1ns/10ps
`default_nettype none
module cc_partner #(
    parameter int HALF = 66
) (
    input  wire logic clk_in,    // Core clock.
    input  wire logic dut_oe_in, // High while the device drives.
    output var logic  lvl_out,   // Level driven on the wire.
    output var logic  oe_out     // High while this model drives.
);
    logic cur;

    // The model starts released.
    initial begin
        lvl_out = 1'b0;
        oe_out  = 1'b0;
        cur     = 1'b0;
    end

    // Sends n bits, bit 0 first, with a low lead-in and a closing edge.
    task automatic send_frame(input logic [31:0] bits, input int n);
        int w;
        w = 0;
        while (dut_oe_in && w < 1000) begin
            @(posedge clk_in);
            w++;
        end
        cur = 1'b0;
        oe_out  <= 1'b1;
        lvl_out <= cur;
        repeat (HALF) @(posedge clk_in);
        for (int i = 0; i < n; i++) begin
            cur = ~cur;
            lvl_out <= cur;
            repeat (HALF) @(posedge clk_in);
            if (bits[i]) begin
                cur = ~cur;
                lvl_out <= cur;
            end
            repeat (HALF) @(posedge clk_in);
        end
        cur = ~cur;
        lvl_out <= cur;
        repeat (HALF) @(posedge clk_in);
        oe_out <= 1'b0;
    endtask
endmodule // cc_partner
`default_nettype wire

// ==== testbench/pd_bmc_line_codec_tb.sv ====
// Self-checking bench for the biphase-mark line codec.
// Assumes a pulled-down wire shared by the codec and the far-end model.
`timescale 1ns/10ps
`default_nettype none
module pd_bmc_line_codec_tb;
    import bmc_pkg::*;
    localparam int HALF  = 8;
    localparam int LIMIT = 40000;
    logic clk_in = 1'b0, srst_in, ce_in, orient_b_in, tx_bit_in, tx_last_in, tx_valid_in;
    logic tx_ready_out, tx_busy_out, rx_bit_out, rx_valid_out;
    logic a_in, a_out, a_oe, b_in, b_out, b_oe, p_lvl, p_oe;
    logic tx_q[$], rx_q[$];
    logic prev_oe = 1'b0, prev_lvl = 1'b0, started = 1'b0, half = 1'b0, saw_full = 1'b0;
    int   mismatches = 0, n_checks = 0, cyc = 0, cnt = 0;
    logic [31:0] data;
    wire  sel_oe  = orient_b_in ? b_oe : a_oe;
    wire  sel_lvl = orient_b_in ? b_out : a_out;
    wire  oth_oe  = orient_b_in ? a_oe : b_oe;

    always #12.5 clk_in = ~clk_in;

    // Wire levels: the driving party wins, otherwise the pull-down.
    assign a_in = a_oe ? a_out : ((p_oe && !orient_b_in) ? p_lvl : 1'b0);
    assign b_in = b_oe ? b_out : ((p_oe && orient_b_in) ? p_lvl : 1'b0);

    pd_bmc_line_codec #(.HALF_CYC(HALF), .DEPTH(FIFO_DEPTH)) i_dut (
        .clk_in(clk_in), .srst_in(srst_in), .ce_in(ce_in), .orient_b_in(orient_b_in),
        .tx_bit_in(tx_bit_in), .tx_last_in(tx_last_in), .tx_valid_in(tx_valid_in),
        .tx_ready_out(tx_ready_out), .tx_busy_out(tx_busy_out), .rx_bit_out(rx_bit_out),
        .rx_valid_out(rx_valid_out), .cc_line_a_in(a_in), .cc_line_a_out(a_out),
        .cc_line_a_oe_out(a_oe), .cc_line_b_in(b_in), .cc_line_b_out(b_out),
        .cc_line_b_oe_out(b_oe));

    cc_partner #(.HALF(HALF_CELL_CYC)) i_partner (
        .clk_in(clk_in), .dut_oe_in(a_oe | b_oe), .lvl_out(p_lvl), .oe_out(p_oe));

    // Compares one value and reports a difference.
    task automatic chk(input logic seen, input logic exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %0t value %b, expected %b", $time, seen, exp);
        end
    endtask

    // Prints the verdict and ends the run.
    task automatic report_and_stop();
        if (mismatches == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // Takes the oldest expected bit off a queue and compares it.
    task automatic pop_chk(inout logic q[$], input logic seen);
        if (q.size() == 0) chk(1'b1, 1'b0);
        else chk(seen, q.pop_front());
    endtask

    // Offers n random bits, the last one marked, noting each accepted bit.
    task automatic send_msg(input int n);
        logic b;
        for (int i = 0; i < n; i++) begin
            b = 1'($urandom % 2);
            tx_valid_in <= 1'b1;
            tx_bit_in   <= b;
            tx_last_in  <= (i == n - 1);
            do begin
                @(posedge clk_in);
                if (!tx_ready_out) saw_full = 1'b1;
            end while (tx_ready_out !== 1'b1);
            tx_q.push_back(b);
        end
        tx_valid_in <= 1'b0;
    endtask

    // Decodes the selected line while the codec drives it.
    always @(posedge clk_in) begin
        if (!srst_in) begin
            chk(oth_oe, 1'b0);
            if (sel_oe) begin
                chk(tx_busy_out, 1'b1);
                if (!prev_oe) begin
                    chk(sel_lvl, 1'b0);
                    started = 1'b0;
                    half = 1'b0;
                    cnt = 1;
                end else if (sel_lvl !== prev_lvl) begin
                    if (!started) begin
                        chk(cnt == HALF, 1'b1);
                        started = 1'b1;
                    end else if (cnt == 2 * HALF && !half) pop_chk(tx_q, 1'b0);
                    else if (cnt == HALF && half) begin
                        pop_chk(tx_q, 1'b1);
                        half = 1'b0;
                    end else if (cnt == HALF) half = 1'b1;
                    else chk(1'b0, 1'b1);
                    cnt = 1;
                end else cnt++;
            end else if (prev_oe) begin
                chk(cnt == HALF, 1'b1);
                chk(half, 1'b0);
            end
            prev_oe = sel_oe;
            prev_lvl = sel_lvl;
        end
    end

    // Compares each received bit with the oldest one the far end sent.
    always @(posedge clk_in) begin
        if (!srst_in && rx_valid_out === 1'b1) pop_chk(rx_q, rx_bit_out);
    end

    // Cuts a hung run short.
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == LIMIT) begin
            mismatches++;
            report_and_stop();
        end
    end

    // Main sequence: transmit rounds, each followed by a received frame.
    initial begin
        int w;
        data = $urandom(32'h1DB52BA8);
        {srst_in, ce_in, orient_b_in, tx_bit_in, tx_last_in, tx_valid_in} = 6'h30;
        repeat (3) @(posedge clk_in);
        srst_in <= 1'b0;
        @(posedge clk_in);
        chk(tx_ready_out, 1'b1);
        chk(tx_busy_out, 1'b0);
        for (int r = 0; r < 4; r++) begin
            orient_b_in <= 1'(r ^ $urandom % 2);
            @(posedge clk_in);
            if (r == 1) begin
                send_msg(10);
                send_msg(10);
            end else send_msg(20);
            if (r == 0) chk(saw_full, 1'b1);
            w = 0;
            while ((tx_q.size() != 0 || tx_busy_out !== 1'b0) && w < 4000) begin
                @(posedge clk_in);
                w++;
            end
            chk(tx_busy_out, 1'b0);
            repeat (4) @(posedge clk_in);
            data = $urandom;
            for (int i = 0; i < 12; i++) rx_q.push_back(data[i]);
            i_partner.send_frame(data, 12);
            repeat (300) @(posedge clk_in);
            chk(rx_q.size() == 0, 1'b1);
        end
        // A bit offered while the clock enable is low must not start a message.
        ce_in       <= 1'b0;
        tx_valid_in <= 1'b1;
        repeat (4) @(posedge clk_in);
        chk(tx_busy_out, 1'b0);
        chk(a_oe | b_oe, 1'b0);
        tx_valid_in <= 1'b0;
        report_and_stop();
    end
endmodule // pd_bmc_line_codec_tb
`default_nettype wire
